// *** include/ccs_defs.svh ***
// ==========================================================================
// constants of the cpu clock source control block
// ==========================================================================
// holds register offsets, field positions, reset values and limits
// assumes inclusion by bare name from the design files
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

// register offsets on the plain register port
`define CCS_ADDR_W 4
`define CCS_OFS_OSC_MODE 4'h0
`define CCS_OFS_OSC_RUN 4'h1
`define CCS_OFS_CLK_SEL 4'h2
`define CCS_OFS_PIN_STAT 4'h3

// oscillation mode register fields
`define CCS_MODE_EXT_MAIN 7
`define CCS_MODE_MAIN_PIN 6
`define CCS_MODE_SUB_PIN 4
`define CCS_MODE_SUB_DRV_HI 2
`define CCS_MODE_SUB_DRV_LO 1
`define CCS_MODE_MAIN_GAIN 0
`define CCS_MODE_WMASK 8'hd7
`define CCS_MODE_RST 8'h00

// oscillator run register fields
`define CCS_RUN_MAIN_HALT 7
`define CCS_RUN_SUB_HALT 6
`define CCS_RUN_FAST_HALT 0

// clock select register fields
`define CCS_SEL_ON_SUB 7
`define CCS_SEL_SUB_SRC 6
`define CCS_SEL_MAIN_FLAG 5
`define CCS_SEL_MAIN_SRC 4
`define CCS_SEL_DIV_HI 2
`define CCS_SEL_DIV_LO 0
`define CCS_DIV_RST 3'h0
`define CCS_DIV_MAX 3'h5

// option byte fields
`define CCS_OPT_WDT_STBY 0
`define CCS_OPT_WDT_EN 4

// source edge counts and synchroniser inputs
`define CCS_CNT_W 5
`define CCS_SUB_EDGES 5'h01
`define CCS_N_SENSE 5
`define CCS_SN_FAST 0
`define CCS_SN_MAIN 1
`define CCS_SN_SUB 2
`define CCS_SN_XIN 3
`define CCS_SN_XOUT 4

`endif

// *** include/ccs_pkg.sv ***
// ==========================================================================
// types of the cpu clock source control block
// ==========================================================================
// holds the state structs and the active source enum
// assumes ccs_defs.svh is compiled alongside
package ccs_pkg;

  // active cpu source, gray along fast -> main -> sub
  typedef enum logic [1:0] {
    CCS_SRC_FAST = 2'h0,
    CCS_SRC_MAIN = 2'h1,
    CCS_SRC_SUB = 2'h3
  } ccs_src_e;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } ccs_sense_s;

  typedef struct packed {
    logic [7:0] mode;
    logic mode_done;
    logic main_halt;
    logic sub_halt;
    logic fast_halt;
    logic sub_src;
    logic main_src;
    logic [2:0] div;
    ccs_src_e act_src;
    logic [2:0] act_div;
    logic [4:0] cnt;
    logic cpu_clk;
    logic stop_mode;
    logic halt_mode;
    logic fast_en;
    logic main_en;
    logic sub_en;
    logic slow_en;
    logic conv_ok;
    logic [7:0] rdata;
  } ccs_state_s;

endpackage

// *** include/ccs_osc_if.sv ***
// ==========================================================================
// carrier of one synchronised oscillator or pin level
// ==========================================================================
// holds the level and its edge marker
// assumes one sense instance drives it and the core reads it
`timescale 1ns/1ns
interface ccs_osc_if;
  logic level;
  logic edge_seen;
  modport sense_mp (output level, output edge_seen);
  modport user_mp (input level, input edge_seen);
endinterface

// *** logic/ccs_sense.sv ***
// ==========================================================================
// two flip-flop synchroniser with edge marker
// ==========================================================================
// holds one asynchronous input brought into core_clk_in
// assumes the input may change at any time
`timescale 1ns/1ns
module ccs_sense (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic raw_in,
  ccs_osc_if.sense_mp sense
);

  ccs_pkg::ccs_sense_s st_r;
  ccs_pkg::ccs_sense_s st_nxt;

  // shift chain, s1 feeds only s2
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = raw_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // either edge of the settled level
  assign sense.level = st_r.s2;
  assign sense.edge_seen = st_r.s2 ^ st_r.s3;

endmodule // ccs_sense

// *** logic/ccs_clock_ctrl.sv ***
// ==========================================================================
// cpu clock source control
// ==========================================================================
// holds source select, dividers, oscillator run control and standby gating
// assumes oscillator signals arrive asynchronously; register port on core_clk_in
//
// Function
// - main select 0 gives fast oscillator divided by 1,2,4,8,16,32 for codes 0-5
// - stop instruction enters stop mode and halts the fast oscillator
// - writing 1 to the fast halt bit stops the fast oscillator
// - status bits report fast, main or sub as the active cpu source
// - sub crystal pins are input ports after reset and when sub unused
// - sub pin select 1 hands both sub pins to crystal oscillation
// - clearing the sub halt bit starts the sub oscillator
// - oscillation mode register takes one write after reset
// - sub select 1 makes the cpu clock the sub clock divided by two
// - on sub clock peripherals share it; converter flagged as not guaranteed
// - writing 1 to the sub halt bit stops the sub oscillator
// - sub oscillator keeps running in stop mode
// - slow oscillator starts after reset, feeds only watchdog, never the cpu
// - slow oscillator runs whenever the watchdog runs
// - slow oscillator stops by watchdog disable, or standby-disable in halt/stop
// - slow oscillator restarts when that halt or stop is released
// - after reset fast oscillator runs and drives the cpu
// - clearing the fast halt bit restarts the fast oscillator
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`include "ccs_defs.svh"
module ccs_clock_ctrl (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic stop_exec_in,
  input wire logic halt_exec_in,
  input wire logic standby_release_in,
  input wire logic [7:0] option_byte_in,
  input wire logic fast_osc_in,
  input wire logic main_osc_in,
  input wire logic sub_osc_in,
  input wire logic sub_crystal_in_pin_in,
  input wire logic sub_crystal_out_pin_in,
  output logic [7:0] reg_rdata_out,
  output logic cpu_clk_out,
  output logic fast_osc_en_out,
  output logic main_osc_en_out,
  output logic sub_osc_en_out,
  output logic slow_osc_en_out,
  output logic sub_pins_osc_mode_out,
  output logic converter_ok_out
);

  // ========================================================================
  // synchronisers
  // ========================================================================
  ccs_osc_if sense_if[`CCS_N_SENSE] ();
  logic [`CCS_N_SENSE-1:0] raw_vec;
  logic [`CCS_N_SENSE-1:0] lvl_vec;
  logic [`CCS_N_SENSE-1:0] edge_vec;

  // gather the asynchronous inputs
  assign raw_vec = {sub_crystal_out_pin_in, sub_crystal_in_pin_in, sub_osc_in, main_osc_in, fast_osc_in};

  // one synchroniser per asynchronous input
  genvar gi;
  generate
    for (gi = 0; gi < `CCS_N_SENSE; gi = gi + 1) begin : g_sense
      ccs_sense u_sense (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .raw_in(raw_vec[gi]),
        .sense(sense_if[gi].sense_mp)
      );
      assign lvl_vec[gi] = sense_if[gi].level;
      assign edge_vec[gi] = sense_if[gi].edge_seen;
    end
  endgenerate

  // ========================================================================
  // state
  // ========================================================================
  ccs_pkg::ccs_state_s st_r;
  ccs_pkg::ccs_state_s st_nxt;
  ccs_pkg::ccs_src_e req_src;
  logic [2:0] req_div;
  logic src_edge;
  logic [4:0] edge_limit;
  logic toggle;
  logic change_pending;
  logic standby;
  logic wdt_off_standby;

  // edges needed per half period, less one, for a given divider code
  function automatic logic [4:0] half_edges(input logic [2:0] code);
    logic [4:0] lim;
    lim = 5'h00;
    case (code)
      3'h0: lim = 5'h00;
      3'h1: lim = 5'h01;
      3'h2: lim = 5'h03;
      3'h3: lim = 5'h07;
      3'h4: lim = 5'h0f;
      default: lim = 5'h1f;
    endcase
    return lim;
  endfunction

  // requested source from the select bits
  always_comb begin
    if (st_r.sub_src) begin
      req_src = ccs_pkg::CCS_SRC_SUB;
    end else if (st_r.main_src) begin
      req_src = ccs_pkg::CCS_SRC_MAIN;
    end else begin
      req_src = ccs_pkg::CCS_SRC_FAST;
    end
    req_div = (st_r.div > `CCS_DIV_MAX) ? `CCS_DIV_MAX : st_r.div;
  end

  // edge of the source that drives the cpu now
  always_comb begin
    case (st_r.act_src)
      ccs_pkg::CCS_SRC_SUB: begin
        src_edge = edge_vec[`CCS_SN_SUB];
        edge_limit = `CCS_SUB_EDGES;
      end
      ccs_pkg::CCS_SRC_MAIN: begin
        src_edge = edge_vec[`CCS_SN_MAIN];
        edge_limit = half_edges(st_r.act_div);
      end
      default: begin
        src_edge = edge_vec[`CCS_SN_FAST];
        edge_limit = half_edges(st_r.act_div);
      end
    endcase
  end

  assign toggle = src_edge && (st_r.cnt == edge_limit);
  assign change_pending = (req_src != st_r.act_src) || (req_div != st_r.act_div);
  assign standby = st_r.stop_mode || st_r.halt_mode;
  assign wdt_off_standby = !option_byte_in[`CCS_OPT_WDT_STBY] && standby;

  // ========================================================================
  // next state
  // ========================================================================
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;

    // register writes
    if (reg_wr_in) begin
      if (reg_addr_in == `CCS_OFS_OSC_MODE) begin
        if (!st_r.mode_done) begin
          st_nxt.mode = reg_wdata_in & `CCS_MODE_WMASK;
          st_nxt.mode_done = 1'b1;
        end
      end else if (reg_addr_in == `CCS_OFS_OSC_RUN) begin
        st_nxt.main_halt = reg_wdata_in[`CCS_RUN_MAIN_HALT];
        st_nxt.sub_halt = reg_wdata_in[`CCS_RUN_SUB_HALT];
        st_nxt.fast_halt = reg_wdata_in[`CCS_RUN_FAST_HALT];
      end else if (reg_addr_in == `CCS_OFS_CLK_SEL) begin
        st_nxt.sub_src = reg_wdata_in[`CCS_SEL_SUB_SRC];
        st_nxt.main_src = reg_wdata_in[`CCS_SEL_MAIN_SRC];
        st_nxt.div = reg_wdata_in[`CCS_SEL_DIV_HI:`CCS_SEL_DIV_LO];
      end
    end

    // register reads, data stand in the next cycle only
    if (reg_rd_in) begin
      if (reg_addr_in == `CCS_OFS_OSC_MODE) begin
        st_nxt.rdata = st_r.mode;
      end else if (reg_addr_in == `CCS_OFS_OSC_RUN) begin
        st_nxt.rdata[`CCS_RUN_MAIN_HALT] = st_r.main_halt;
        st_nxt.rdata[`CCS_RUN_SUB_HALT] = st_r.sub_halt;
        st_nxt.rdata[`CCS_RUN_FAST_HALT] = st_r.fast_halt;
      end else if (reg_addr_in == `CCS_OFS_CLK_SEL) begin
        st_nxt.rdata[`CCS_SEL_ON_SUB] = st_r.act_src[1];
        st_nxt.rdata[`CCS_SEL_SUB_SRC] = st_r.sub_src;
        st_nxt.rdata[`CCS_SEL_MAIN_FLAG] = st_r.act_src[0];
        st_nxt.rdata[`CCS_SEL_MAIN_SRC] = st_r.main_src;
        st_nxt.rdata[`CCS_SEL_DIV_HI:`CCS_SEL_DIV_LO] = st_r.div;
      end else if (reg_addr_in == `CCS_OFS_PIN_STAT) begin
        // port levels read as zero while the pins oscillate
        st_nxt.rdata[1:0] = st_r.mode[`CCS_MODE_SUB_PIN] ? 2'h0
          : {lvl_vec[`CCS_SN_XOUT], lvl_vec[`CCS_SN_XIN]};
      end
    end

    // standby entry and release
    if (standby_release_in) begin
      st_nxt.stop_mode = 1'b0;
      st_nxt.halt_mode = 1'b0;
    end else if (stop_exec_in) begin
      st_nxt.stop_mode = 1'b1;
    end else if (halt_exec_in) begin
      st_nxt.halt_mode = 1'b1;
    end

    // cpu clock divider, switch only at the rising point of a low phase
    if (toggle) begin
      if (!st_r.cpu_clk && change_pending) begin
        st_nxt.act_src = req_src;
        st_nxt.act_div = req_div;
        st_nxt.cnt = 5'h00;
      end else begin
        st_nxt.cpu_clk = !st_r.cpu_clk;
        st_nxt.cnt = 5'h00;
      end
    end else if (src_edge) begin
      st_nxt.cnt = st_r.cnt + 5'h01;
    end

    // oscillator enables
    st_nxt.fast_en = !st_nxt.fast_halt && !st_nxt.stop_mode;
    st_nxt.main_en = !st_nxt.main_halt && !st_nxt.stop_mode;
    st_nxt.sub_en = !st_nxt.sub_halt;
    st_nxt.slow_en = option_byte_in[`CCS_OPT_WDT_EN]
      && !(!option_byte_in[`CCS_OPT_WDT_STBY] && (st_nxt.stop_mode || st_nxt.halt_mode));
    st_nxt.conv_ok = (st_nxt.act_src != ccs_pkg::CCS_SRC_SUB);
  end

  // ========================================================================
  // registers
  // ========================================================================
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= '0;
      st_r.mode <= `CCS_MODE_RST;
      st_r.main_halt <= 1'b1;
      st_r.sub_halt <= 1'b1;
      st_r.div <= `CCS_DIV_RST;
      st_r.act_src <= ccs_pkg::CCS_SRC_FAST;
      st_r.act_div <= `CCS_DIV_RST;
      st_r.fast_en <= 1'b1;
      st_r.slow_en <= 1'b1;
      st_r.conv_ok <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from state
  assign reg_rdata_out = st_r.rdata;
  assign cpu_clk_out = st_r.cpu_clk;
  assign fast_osc_en_out = st_r.fast_en;
  assign main_osc_en_out = st_r.main_en;
  assign sub_osc_en_out = st_r.sub_en;
  assign slow_osc_en_out = st_r.slow_en;
  assign sub_pins_osc_mode_out = st_r.mode[`CCS_MODE_SUB_PIN];
  assign converter_ok_out = st_r.conv_ok;

  // ========================================================================
  // assertions
  // ========================================================================
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_stop_taken;
    stop_exec_in && !standby_release_in;
  endsequence

  sequence s_fast_off;
    !fast_osc_en_out;
  endsequence

  // halt or stop taken while the watchdog may not run in standby
  sequence s_standby_no_wdt;
    (halt_exec_in || stop_exec_in) && !standby_release_in && !option_byte_in[`CCS_OPT_WDT_STBY];
  endsequence

  // fast oscillator stop and restart
  AST_STOP_HALTS_FAST: assert property (s_stop_taken |=> s_fast_off)
    else $error("fast oscillator runs after stop");
  AST_FAST_HALT_BIT: assert property (reg_wr_in && reg_addr_in == `CCS_OFS_OSC_RUN
    && reg_wdata_in[`CCS_RUN_FAST_HALT] |=> !fast_osc_en_out)
    else $error("fast halt write ignored");
  AST_FAST_RESTART: assert property (reg_wr_in && reg_addr_in == `CCS_OFS_OSC_RUN
    && !reg_wdata_in[`CCS_RUN_FAST_HALT] && !st_r.stop_mode && !stop_exec_in
    |=> fast_osc_en_out)
    else $error("fast oscillator not restarted");

  // sub oscillator control
  AST_SUB_HALT_BIT: assert property (reg_wr_in && reg_addr_in == `CCS_OFS_OSC_RUN
    && reg_wdata_in[`CCS_RUN_SUB_HALT] |=> !sub_osc_en_out)
    else $error("sub halt write ignored");
  AST_SUB_START_STOP: assert property (reg_wr_in && reg_addr_in == `CCS_OFS_OSC_RUN
    |=> sub_osc_en_out == !$past(reg_wdata_in[`CCS_RUN_SUB_HALT]))
    else $error("sub oscillator enable wrong");
  AST_SUB_IGNORES_STOP: assert property (stop_exec_in ##1 sub_osc_en_out[*1]
    |=> sub_osc_en_out)
    else $error("sub oscillator stopped by stop");

  // oscillation mode register
  AST_MODE_FIRST: assert property (!st_r.mode_done && reg_wr_in && reg_addr_in == `CCS_OFS_OSC_MODE
    |=> sub_pins_osc_mode_out == $past(reg_wdata_in[`CCS_MODE_SUB_PIN]))
    else $error("sub pin mode not taken from first write");
  AST_MODE_ONCE: assert property (st_r.mode_done && reg_wr_in && reg_addr_in == `CCS_OFS_OSC_MODE
    |=> $stable(st_r.mode))
    else $error("oscillation mode rewritten");

  // glitch free switching
  AST_CPU_CLK_HOLD: assert property (!toggle |=> $stable(cpu_clk_out))
    else $error("cpu clock moved without a source edge");
  AST_STATUS_STABLE_NO_SWITCH: assert property (!(toggle && !st_r.cpu_clk)
    |=> $stable(st_r.act_src))
    else $error("status changed outside a switch point");
  AST_SWITCH_LOW: assert property ($changed(st_r.act_src) |-> !cpu_clk_out && $stable(cpu_clk_out))
    else $error("source switched while clock high");

  // slow oscillator gating
  AST_SLOW_STANDBY_STOP: assert property (s_standby_no_wdt |=> !slow_osc_en_out)
    else $error("slow oscillator runs in standby with watchdog off");
  AST_SLOW_WDT_OFF: assert property (!option_byte_in[`CCS_OPT_WDT_EN] ##1 !option_byte_in[`CCS_OPT_WDT_EN]
    |-> !slow_osc_en_out)
    else $error("slow oscillator runs with watchdog off");
  AST_SLOW_RESTART: assert property (standby_release_in && option_byte_in[`CCS_OPT_WDT_EN]
    ##1 option_byte_in[`CCS_OPT_WDT_EN] |-> slow_osc_en_out)
    else $error("slow oscillator not restarted on release");
  AST_SLOW_RUNS: assert property (option_byte_in[`CCS_OPT_WDT_EN] && !wdt_off_standby
    && !stop_exec_in && !halt_exec_in |=> option_byte_in[`CCS_OPT_WDT_EN] |-> slow_osc_en_out)
    else $error("slow oscillator stopped while watchdog runs");

  // status bits, pins and converter flag
  AST_STATUS_READ: assert property (reg_rd_in && reg_addr_in == `CCS_OFS_CLK_SEL
    |=> reg_rdata_out[`CCS_SEL_ON_SUB] == ($past(st_r.act_src) == ccs_pkg::CCS_SRC_SUB)
    && (reg_rdata_out[`CCS_SEL_ON_SUB]
    || reg_rdata_out[`CCS_SEL_MAIN_FLAG] == ($past(st_r.act_src) == ccs_pkg::CCS_SRC_MAIN)))
    else $error("clock status bits wrong");
  AST_STATUS_ENCODING: assert property (st_r.act_src != 2'h2)
    else $error("illegal active source");
  AST_PINS_FOLLOW: assert property (sub_pins_osc_mode_out |-> reg_rd_in && reg_addr_in == `CCS_OFS_PIN_STAT
    |=> reg_rdata_out[1:0] == 2'h0)
    else $error("port levels seen in oscillator mode");
  AST_CONVERTER_FLAG: assert property (st_r.act_src == ccs_pkg::CCS_SRC_SUB |-> !converter_ok_out)
    else $error("converter flagged usable on sub clock");

endmodule // ccs_clock_ctrl

// *** sim/tb_top.sv ***
// ==========================================================================
// self-checking bench of the cpu clock source control block
// ==========================================================================
// holds oscillator stand-ins, register tasks, divider rows and hand tests
// assumes ccs_clock_ctrl and its include files are compiled before it
`timescale 1ns/1ns
module tb_top;
  typedef struct {logic [7:0] sel; logic [7:0] per;} ccs_row_s;
  logic core_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic stop_exec_in = 1'b0;
  logic halt_exec_in = 1'b0;
  logic standby_release_in = 1'b0;
  logic [7:0] option_byte_in = 8'h11;
  logic fast_osc_in = 1'b0;
  logic main_osc_in = 1'b0;
  logic sub_osc_in = 1'b0;
  logic sub_crystal_in_pin_in = 1'b1;
  logic sub_crystal_out_pin_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic cpu_clk_out, fast_osc_en_out, main_osc_en_out, sub_osc_en_out;
  logic slow_osc_en_out, sub_pins_osc_mode_out, converter_ok_out;
  logic [7:0] rd_val;
  int error_cnt = 0;
  int num_checks = 0;
  int tick = 0;
  int p;
  // divider codes with the expected cpu period in core cycles, fast half period 2
  ccs_row_s rows [7] = '{'{8'h00, 8'h04}, '{8'h01, 8'h08}, '{8'h02, 8'h10}, '{8'h03, 8'h20},
                         '{8'h04, 8'h40}, '{8'h05, 8'h80}, '{8'h06, 8'h80}};

  ccs_clock_ctrl uut (.core_clk_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .stop_exec_in, .halt_exec_in, .standby_release_in, .option_byte_in, .fast_osc_in, .main_osc_in,
    .sub_osc_in, .sub_crystal_in_pin_in, .sub_crystal_out_pin_in, .reg_rdata_out, .cpu_clk_out,
    .fast_osc_en_out, .main_osc_en_out, .sub_osc_en_out, .slow_osc_en_out, .sub_pins_osc_mode_out,
    .converter_ok_out);

  // ==========================================================================
  // clock and oscillator stand-ins
  // ==========================================================================
  // core clock, 10 ns period
  always #5 core_clk_in = ~core_clk_in;

  // oscillators swing only while enabled; half periods 2, 3 and 4 cycles
  always @(posedge core_clk_in) begin
    tick <= tick + 1;
    if (fast_osc_en_out === 1'b1 && tick % 2 == 0) fast_osc_in <= ~fast_osc_in;
    if (main_osc_en_out === 1'b1 && tick % 3 == 0) main_osc_in <= ~main_osc_in;
    if (sub_osc_en_out === 1'b1 && tick % 4 == 0) sub_osc_in <= ~sub_osc_in;
  end

  // ==========================================================================
  // tasks
  // ==========================================================================
  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one register write, strobe one cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  // one register read, data taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    rd_val = reg_rdata_out;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  // standby pulse: {stop, halt, release}
  task automatic sb(input logic [2:0] v);
    @(posedge core_clk_in);
    {stop_exec_in, halt_exec_in, standby_release_in} <= v;
    @(posedge core_clk_in);
    {stop_exec_in, halt_exec_in, standby_release_in} <= 3'h0;
  endtask

  // cycles until the next rising cpu clock, bounded
  task automatic wait_rise(output int k);
    k = 0;
    while (k < 800 && cpu_clk_out !== 1'b0) begin
      cyc(1);
      k++;
    end
    while (k < 800 && cpu_clk_out !== 1'b1) begin
      cyc(1);
      k++;
    end
    if (k >= 800) begin
      error_cnt++;
      $display("wrong value cpu clock rise expected within 800 seen none");
      wrap_up();
    end
  endtask

  // first two rises skip any pending switch, then the period up to the third rise is counted
  task automatic period(output int n);
    int k;
    wait_rise(k);
    wait_rise(k);
    wait_rise(n);
  endtask

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    repeat (4) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    cyc(2);
    chk("fast enable", 8'h01, {7'h0, fast_osc_en_out});
    chk("sub enable", 8'h00, {7'h0, sub_osc_en_out});
    chk("slow enable", 8'h01, {7'h0, slow_osc_en_out});
    chk("pins mode", 8'h00, {7'h0, sub_pins_osc_mode_out});
    rd(4'h1);
    chk("run reg", 8'hc0, rd_val);
    rd(4'h2);
    chk("select reg", 8'h00, rd_val);
    rd(4'h3);
    chk("pin status", 8'h01, rd_val);
    rd(4'hf);
    chk("unmapped", 8'h00, rd_val);
    $display("test reset done");
    // divider rows on the fast oscillator
    foreach (rows[i]) begin
      wr(4'h2, rows[i].sel);
      period(p);
      chk("fast period", rows[i].per, p[7:0]);
      rd(4'h2);
      chk("select readback", rows[i].sel, rd_val);
    end
    $display("test divider rows done");
    // main source, then fast halt and restart
    wr(4'h1, 8'h40);
    cyc(2);
    chk("main enable", 8'h01, {7'h0, main_osc_en_out});
    wr(4'h2, 8'h10);
    period(p);
    chk("main period", 8'h06, p[7:0]);
    rd(4'h2);
    chk("select on main", 8'h30, rd_val);
    wr(4'h1, 8'h41);
    cyc(2);
    chk("fast halted", 8'h00, {7'h0, fast_osc_en_out});
    wr(4'h1, 8'h40);
    cyc(2);
    chk("fast restarted", 8'h01, {7'h0, fast_osc_en_out});
    cyc(1000);
    wr(4'h2, 8'h03);
    period(p);
    chk("fast div8 period", 8'h20, p[7:0]);
    rd(4'h2);
    chk("select back on fast", 8'h03, rd_val);
    $display("test main switch done");
    // oscillation mode register takes one write
    wr(4'h0, 8'h10);
    cyc(2);
    chk("pins crystal mode", 8'h01, {7'h0, sub_pins_osc_mode_out});
    rd(4'h0);
    chk("mode first write", 8'h10, rd_val);
    wr(4'h0, 8'hd7);
    rd(4'h0);
    chk("mode second write", 8'h10, rd_val);
    rd(4'h3);
    chk("pin status masked", 8'h00, rd_val);
    $display("test mode register done");
    // sub source
    wr(4'h1, 8'h00);
    cyc(2);
    chk("sub enable on", 8'h01, {7'h0, sub_osc_en_out});
    cyc(200);
    wr(4'h2, 8'h40);
    period(p);
    chk("sub period", 8'h10, p[7:0]);
    rd(4'h2);
    chk("select on sub", 8'hc0, rd_val & 8'hdf);
    chk("converter flag", 8'h00, {7'h0, converter_ok_out});
    sb(3'h4);
    cyc(2);
    chk("fast in stop", 8'h00, {7'h0, fast_osc_en_out});
    chk("sub in stop", 8'h01, {7'h0, sub_osc_en_out});
    chk("slow in stop", 8'h01, {7'h0, slow_osc_en_out});
    sb(3'h1);
    cyc(2);
    chk("fast after stop", 8'h01, {7'h0, fast_osc_en_out});
    wr(4'h2, 8'h00);
    period(p);
    chk("fast period again", 8'h04, p[7:0]);
    rd(4'h2);
    chk("select off sub", 8'h00, rd_val);
    chk("converter back", 8'h01, {7'h0, converter_ok_out});
    wr(4'h1, 8'h40);
    cyc(2);
    chk("sub halted", 8'h00, {7'h0, sub_osc_en_out});
    $display("test sub source done");
    // slow oscillator gating by the option byte
    @(posedge core_clk_in);
    option_byte_in <= 8'h10;
    sb(3'h2);
    cyc(2);
    chk("slow in halt", 8'h00, {7'h0, slow_osc_en_out});
    sb(3'h1);
    cyc(2);
    chk("slow after halt", 8'h01, {7'h0, slow_osc_en_out});
    @(posedge core_clk_in);
    option_byte_in <= 8'h00;
    cyc(3);
    chk("slow watchdog off", 8'h00, {7'h0, slow_osc_en_out});
    @(posedge core_clk_in);
    option_byte_in <= 8'h11;
    cyc(3);
    chk("slow watchdog on", 8'h01, {7'h0, slow_osc_en_out});
    $display("test slow oscillator done");
    // second reset in mid-run
    @(posedge core_clk_in);
    rst_b_in <= 1'b0;
    #2;
    chk("fast in reset", 8'h01, {7'h0, fast_osc_en_out});
    chk("main in reset", 8'h00, {7'h0, main_osc_en_out});
    repeat (3) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    cyc(2);
    rd(4'h0);
    chk("mode after reset", 8'h00, rd_val);
    wr(4'h0, 8'h10);
    rd(4'h0);
    chk("mode rewritten", 8'h10, rd_val);
    $display("test second reset done");
    wrap_up();
  end
endmodule // tb_top
